// ==== src/slp_defines.svh ====
`ifndef SLP_DEFINES_SVH
`define SLP_DEFINES_SVH

`define SLP_NSTRAP       10
`define SLP_NLED         16
`define SLP_STRAP_DFLT   10'h30A
`define SLP_SETTLE_NS    200
`define SLP_CLK_MHZ      25
`define SLP_SETTLE_CYC   ((`SLP_SETTLE_NS * `SLP_CLK_MHZ + 999) / 1000)

`define SLP_ADR_CTRL     8'h00
`define SLP_ADR_STRAP    8'h04
`define SLP_ADR_STATUS   8'h08
`define SLP_ADR_LEDS     8'h0C

`define SLP_CTRL_SERIAL  0
`define SLP_ST_DONE      0

`define SLP_BIT_SKIPMEM  1
`define SLP_BIT_MGMTVOL  2
`define SLP_BIT_CLKF1    3
`define SLP_BIT_WAN      4
`define SLP_BIT_MGMTMODE 6
`define SLP_BIT_CPUEE    8
`define SLP_BIT_HWFWD    9

`endif

// ==== src/slp_led_driver.sv ====
`include "slp_defines.svh"

module slp_led_driver (
	input  wire logic                 clk,
	input  wire logic                 rst,
	slp_pol_if.dst                    pol,
	input  wire logic [`SLP_NLED-1:0] led_status,
	output logic      [`SLP_NLED-1:0] led_out,
	output logic      [`SLP_NLED-1:0] led_oe
);
	logic [`SLP_NLED-1:0] next_out;
	logic [`SLP_NLED-1:0] next_oe;

	genvar g;
	generate
		for (g = 0; g < `SLP_NLED; g++) begin : g_led
			always_comb begin
				// serial mode forces active low everywhere
				if (pol.serial_mode) begin
					next_out[g] = ~led_status[g];
				end else begin
					next_out[g] = pol.polarity[g] ? led_status[g]
						: ~led_status[g];
				end
				next_oe[g] = pol.drive_en;
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			led_out <= '0;
			led_oe  <= '0;
		end else begin
			led_out <= next_out;
			led_oe  <= next_oe;
		end
	end

	property p_no_drive_early;
		@(posedge clk) disable iff (rst)
		!$past(pol.drive_en) |-> (led_oe == '0);
	endproperty
	a_no_drive_early: assert property (p_no_drive_early)
		else $error("led driven during reset sequence");

	property p_polarity;
		@(posedge clk) disable iff (rst)
		($past(pol.drive_en) && !$past(pol.serial_mode)) |->
			(led_out == ~($past(pol.polarity) ^ $past(led_status)));
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("parallel led polarity wrong");

	property p_serial_low;
		@(posedge clk) disable iff (rst)
		$past(pol.serial_mode) |-> (led_out == ~$past(led_status));
	endproperty
	a_serial_low: assert property (p_serial_low)
		else $error("serial mode not active low");
endmodule

// ==== src/slp_pkg.sv ====
package slp_pkg;
	typedef enum logic [2:0] {
		SLP_SAMPLE = 3'h1,
		SLP_SETTLE = 3'h2,
		SLP_RUN    = 3'h4
	} slp_state_t;
endpackage

// ==== src/slp_pol_if.sv ====
`include "slp_defines.svh"

interface slp_pol_if;
	logic [`SLP_NLED-1:0] polarity;
	logic                 serial_mode;
	logic                 drive_en;

	modport src (output polarity, output serial_mode, output drive_en);
	modport dst (input polarity, input serial_mode, input drive_en);
endinterface

// ==== src/slp_strap_capture.sv ====
`include "slp_defines.svh"

module slp_strap_capture (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic [`SLP_NSTRAP-1:0] pin_in,
	output logic      [`SLP_NSTRAP-1:0] strap,
	output logic                        done
);
	localparam int CYC = `SLP_SETTLE_CYC;

	slp_pkg::slp_state_t          state;
	slp_pkg::slp_state_t          next_state;
	logic [7:0]                   cnt;
	logic [7:0]                   next_cnt;
	logic [`SLP_NSTRAP-1:0]       next_strap;

	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_strap = strap;
		case (state)
			slp_pkg::SLP_SAMPLE: begin
				// keeps sampling while pins are still inputs
				next_strap = pin_in;
				next_state = slp_pkg::SLP_SETTLE;
				next_cnt   = 8'h00;
			end
			slp_pkg::SLP_SETTLE: begin
				// pins stay undriven so straps are not fought
				next_strap = pin_in;
				if (cnt == 8'(CYC - 1)) begin
					next_state = slp_pkg::SLP_RUN;
				end else begin
					next_cnt = cnt + 8'h01;
				end
			end
			slp_pkg::SLP_RUN: begin
				next_strap = strap;
			end
			default: begin
				next_state = slp_pkg::SLP_SAMPLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= slp_pkg::SLP_SAMPLE;
			cnt   <= 8'h00;
			strap <= `SLP_STRAP_DFLT;
			done  <= 1'b0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			strap <= next_strap;
			done  <= (next_state == slp_pkg::SLP_RUN);
		end
	end

	property p_strap_hold;
		@(posedge clk) disable iff (rst)
		(done && $past(done)) |-> $stable(strap);
	endproperty
	a_strap_hold: assert property (p_strap_hold)
		else $error("strap changed after capture");

	property p_settle_len;
		@(posedge clk) disable iff (rst)
		$rose(done) |-> $past(state == slp_pkg::SLP_SETTLE);
	endproperty
	a_settle_len: assert property (p_settle_len)
		else $error("done rose without settle");
endmodule

// ==== src/slp_top.sv ====
`include "slp_defines.svh"

module slp_top (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [`SLP_NLED-1:0] led_in,
	output logic      [`SLP_NLED-1:0] led_out,
	output logic      [`SLP_NLED-1:0] led_oe,
	output logic                      skip_memory_selftest,
	output logic                      mgmt_port_voltage_select,
	output logic                      clock_freq_select_bit1,
	output logic                      wan_port_mode,
	output logic                      mgmt_port_mode,
	output logic                      cpu_eeprom_select,
	output logic                      hw_forwarding_enable,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o
);
	logic [`SLP_NSTRAP-1:0] strap;
	logic                   done;
	logic                   serial_mode;
	logic                   next_serial;
	logic [`SLP_NLED-1:0]   led_status;
	logic [`SLP_NLED-1:0]   next_status;
	logic [31:0]            next_dat;
	logic                   next_ack;
	logic [6:0]             next_cfg;
	logic                   req;
	logic                   wr;
	// reset image of the straps, so checks can pick single bits
	localparam logic [`SLP_NSTRAP-1:0] DFLT = `SLP_STRAP_DFLT;

	slp_pol_if pol ();

	slp_strap_capture u_cap (
		.clk    (clk),
		.rst    (rst),
		.pin_in (led_in[`SLP_NSTRAP-1:0]),
		.strap  (strap),
		.done   (done)
	);

	// upper pins carry no strap, so their polarity is fixed low
	assign pol.polarity    = {{(`SLP_NLED-`SLP_NSTRAP){1'b0}}, strap};
	assign pol.serial_mode = serial_mode;
	assign pol.drive_en    = done;

	slp_led_driver u_drv (
		.clk        (clk),
		.rst        (rst),
		.pol        (pol),
		.led_status (led_status),
		.led_out    (led_out),
		.led_oe     (led_oe)
	);

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// writes land at the edge the master samples ack, not one early
	assign wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;

	always_comb begin
		next_serial = serial_mode;
		next_status = led_status;
		next_dat    = 32'h0000_0000;
		next_ack    = req;
		if (wr) begin
			case (wb_adr_i)
				`SLP_ADR_CTRL: begin
					if (wb_sel_i[0]) begin
						next_serial = wb_dat_i[`SLP_CTRL_SERIAL];
					end
				end
				`SLP_ADR_LEDS: begin
					if (wb_sel_i[0]) begin
						next_status[7:0] = wb_dat_i[7:0];
					end
					if (wb_sel_i[1]) begin
						next_status[15:8] = wb_dat_i[15:8];
					end
				end
				default: begin
					next_status = led_status;
				end
			endcase
		end else if (req && !wb_we_i) begin
			case (wb_adr_i)
				`SLP_ADR_CTRL: begin
					next_dat[`SLP_CTRL_SERIAL] = serial_mode;
				end
				`SLP_ADR_STRAP: begin
					next_dat[`SLP_NSTRAP-1:0] = strap;
				end
				`SLP_ADR_STATUS: begin
					next_dat[`SLP_ST_DONE] = done;
				end
				`SLP_ADR_LEDS: begin
					next_dat[`SLP_NLED-1:0] = led_status;
				end
				default: begin
					next_dat = 32'h0000_0000;
				end
			endcase
		end
	end

	// options read the live capture until done, then it freezes
	always_comb begin
		next_cfg = {strap[`SLP_BIT_HWFWD], strap[`SLP_BIT_CPUEE],
			strap[`SLP_BIT_MGMTMODE], strap[`SLP_BIT_WAN],
			strap[`SLP_BIT_CLKF1], strap[`SLP_BIT_MGMTVOL],
			strap[`SLP_BIT_SKIPMEM]};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			serial_mode              <= 1'b0;
			led_status               <= 16'h0000;
			wb_dat_o                 <= 32'h0000_0000;
			wb_ack_o                 <= 1'b0;
			skip_memory_selftest     <= 1'b1;
			mgmt_port_voltage_select <= 1'b0;
			clock_freq_select_bit1   <= 1'b1;
			wan_port_mode            <= 1'b0;
			mgmt_port_mode           <= 1'b0;
			cpu_eeprom_select        <= 1'b1;
			hw_forwarding_enable     <= 1'b1;
		end else begin
			serial_mode              <= next_serial;
			led_status               <= next_status;
			wb_dat_o                 <= next_dat;
			wb_ack_o                 <= next_ack;
			skip_memory_selftest     <= next_cfg[0];
			mgmt_port_voltage_select <= next_cfg[1];
			clock_freq_select_bit1   <= next_cfg[2];
			wan_port_mode            <= next_cfg[3];
			mgmt_port_mode           <= next_cfg[4];
			cpu_eeprom_select        <= next_cfg[5];
			hw_forwarding_enable     <= next_cfg[6];
		end
	end

	property p_cfg_follows;
		@(posedge clk) disable iff (rst)
		$past(done) |-> (hw_forwarding_enable == strap[`SLP_BIT_HWFWD]);
	endproperty
	a_cfg_follows: assert property (p_cfg_follows)
		else $error("option does not follow strap");

	property p_high_pins_low;
		@(posedge clk) disable iff (rst)
		(led_oe[15] && !$past(serial_mode)) |->
			(led_out[15:10] == ~$past(led_status[15:10]));
	endproperty
	a_high_pins_low: assert property (p_high_pins_low)
		else $error("upper led pins not active low");

	property p_ack_one;
		@(posedge clk) disable iff (rst)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("ack held longer than one cycle");

	property p_low_idle;
		@(posedge clk) disable iff (rst)
		(led_oe[0] && !$past(strap[0]) && !$past(led_status[0]))
			|-> led_out[0];
	endproperty
	a_low_idle: assert property (p_low_idle)
		else $error("low strap led not idle high");

	property p_ack_next;
		@(posedge clk) disable iff (rst)
		req |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("request not acknowledged next cycle");

	property p_ack_quiet;
		@(posedge clk) disable iff (rst)
		!req |=> !wb_ack_o;
	endproperty
	a_ack_quiet: assert property (p_ack_quiet)
		else $error("ack without request");

	property p_dat_quiet;
		@(posedge clk) disable iff (rst)
		!wb_ack_o |-> (wb_dat_o == 32'h0000_0000);
	endproperty
	a_dat_quiet: assert property (p_dat_quiet)
		else $error("read data outside ack");

	property p_rd_strap;
		@(posedge clk) disable iff (rst)
		(req && !wb_we_i && wb_adr_i == `SLP_ADR_STRAP) |=>
			(wb_dat_o == {22'h0, $past(strap)});
	endproperty
	a_rd_strap: assert property (p_rd_strap)
		else $error("strap readback wrong");

	property p_rd_status;
		@(posedge clk) disable iff (rst)
		(req && !wb_we_i && wb_adr_i == `SLP_ADR_STATUS) |=>
			(wb_dat_o == {31'h0, $past(done)});
	endproperty
	a_rd_status: assert property (p_rd_status)
		else $error("status readback wrong");

	property p_rd_ctrl;
		@(posedge clk) disable iff (rst)
		(req && !wb_we_i && wb_adr_i == `SLP_ADR_CTRL) |=>
			(wb_dat_o == {31'h0, $past(serial_mode)});
	endproperty
	a_rd_ctrl: assert property (p_rd_ctrl)
		else $error("control readback wrong");

	property p_rd_leds;
		@(posedge clk) disable iff (rst)
		(req && !wb_we_i && wb_adr_i == `SLP_ADR_LEDS) |=>
			(wb_dat_o == {16'h0, $past(led_status)});
	endproperty
	a_rd_leds: assert property (p_rd_leds)
		else $error("led status readback wrong");

	property p_rd_other;
		@(posedge clk) disable iff (rst)
		(req && !wb_we_i && !(wb_adr_i inside {`SLP_ADR_CTRL,
			`SLP_ADR_STRAP, `SLP_ADR_STATUS, `SLP_ADR_LEDS})) |=>
			(wb_dat_o == 32'h0000_0000);
	endproperty
	a_rd_other: assert property (p_rd_other)
		else $error("unmapped read not zero");

	property p_led_write;
		@(posedge clk) disable iff (rst)
		(wr && wb_adr_i == `SLP_ADR_LEDS && wb_sel_i[1:0] == 2'h3) |=>
			(led_status == $past(wb_dat_i[15:0]));
	endproperty
	a_led_write: assert property (p_led_write)
		else $error("led status write lost");

	property p_led_hold;
		@(posedge clk) disable iff (rst)
		!(wr && wb_adr_i == `SLP_ADR_LEDS) |=> $stable(led_status);
	endproperty
	a_led_hold: assert property (p_led_hold)
		else $error("led status changed without write");

	property p_serial_write;
		@(posedge clk) disable iff (rst)
		(wr && wb_adr_i == `SLP_ADR_CTRL && wb_sel_i[0]) |=>
			(serial_mode == $past(wb_dat_i[`SLP_CTRL_SERIAL]));
	endproperty
	a_serial_write: assert property (p_serial_write)
		else $error("serial mode write lost");

	property p_serial_hold;
		@(posedge clk) disable iff (rst)
		!(wr && wb_adr_i == `SLP_ADR_CTRL) |=> $stable(serial_mode);
	endproperty
	a_serial_hold: assert property (p_serial_hold)
		else $error("serial mode changed without write");

	property p_oe_done;
		@(posedge clk) disable iff (rst)
		(led_oe == {`SLP_NLED{$past(done)}});
	endproperty
	a_oe_done: assert property (p_oe_done)
		else $error("led drive not tied to capture done");

	property p_opts_match;
		@(posedge clk) disable iff (rst)
		$past(done) |-> ({skip_memory_selftest, mgmt_port_voltage_select,
			clock_freq_select_bit1, wan_port_mode, mgmt_port_mode,
			cpu_eeprom_select} == {strap[`SLP_BIT_SKIPMEM],
			strap[`SLP_BIT_MGMTVOL], strap[`SLP_BIT_CLKF1],
			strap[`SLP_BIT_WAN], strap[`SLP_BIT_MGMTMODE],
			strap[`SLP_BIT_CPUEE]});
	endproperty
	a_opts_match: assert property (p_opts_match)
		else $error("option outputs do not follow straps");

	// options trail the capture by one edge, so wait two
	property p_opts_frozen;
		@(posedge clk) disable iff (rst)
		(done && $past(done, 2)) |-> $stable({skip_memory_selftest,
			mgmt_port_voltage_select, clock_freq_select_bit1,
			wan_port_mode, mgmt_port_mode, cpu_eeprom_select,
			hw_forwarding_enable});
	endproperty
	a_opts_frozen: assert property (p_opts_frozen)
		else $error("option changed after capture");

	property p_dflt_after_rst;
		@(posedge clk) disable iff (rst)
		$past(rst) |-> ((strap == DFLT) && ({skip_memory_selftest,
			mgmt_port_voltage_select, clock_freq_select_bit1,
			wan_port_mode, mgmt_port_mode, cpu_eeprom_select,
			hw_forwarding_enable} == {DFLT[`SLP_BIT_SKIPMEM],
			DFLT[`SLP_BIT_MGMTVOL], DFLT[`SLP_BIT_CLKF1],
			DFLT[`SLP_BIT_WAN], DFLT[`SLP_BIT_MGMTMODE],
			DFLT[`SLP_BIT_CPUEE], DFLT[`SLP_BIT_HWFWD]}));
	endproperty
	a_dflt_after_rst: assert property (p_dflt_after_rst)
		else $error("reset defaults wrong");

	c_done: cover property (@(posedge clk) $rose(done));
	c_serial: cover property (@(posedge clk) serial_mode && led_oe[0]);
	c_strap_hi: cover property (@(posedge clk) done && strap[0]);
	c_bus_write: cover property (@(posedge clk) wr);
	c_unfitted: cover property (@(posedge clk) done && strap == DFLT);
endmodule

// ==== test/slp_board.sv ====
`include "slp_defines.svh"

module slp_board (
	input  wire logic                   fitted,
	input  wire logic [`SLP_NSTRAP-1:0] strap_lvl,
	input  wire logic [`SLP_NLED-1:0]   led_out,
	input  wire logic [`SLP_NLED-1:0]   led_oe,
	output logic      [`SLP_NLED-1:0]   led_in,
	output logic      [`SLP_NLED-1:0]   lit
);
	timeunit 1ns;
	timeprecision 1ps;
	// upper pulls are not given; plain default
	parameter logic [5:0] UPPER_PULL = 6'h00;
	logic [`SLP_NLED-1:0] lvl;
	logic [`SLP_NLED-1:0] pol;
	// fitted resistors override the internal pulls
	assign lvl = {UPPER_PULL, fitted ? strap_lvl : `SLP_STRAP_DFLT};
	// released pins fall back to their pull level
	assign led_in = (led_oe & led_out) | (~led_oe & lvl);
	// each strapped led circuit is wired for the level its strap produces; the upper six are wired active low
	assign pol = {6'h00, lvl[`SLP_NSTRAP-1:0]};
	assign lit = led_oe & ~(led_out ^ pol);
endmodule

// ==== test/strap_latch_led_polarity_tb.sv ====
`include "slp_defines.svh"

module strap_latch_led_polarity_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, fitted, cyc, stb, we;
	logic [9:0]  s_lvl, cap;
	logic [7:0]  adr;
	logic [31:0] dat_w, dat_r, rd;
	logic [15:0] led_in, led_out, led_oe, lit, st;
	logic [6:0]  opts;
	logic        ack;
	int          mismatches, checks_done, cycles;
	logic [10:0] cases [5] = '{11'h000, 11'h4CF, 11'h555, 11'h6AA, 11'h7FF};

	slp_top u_dut (.clk(clk), .rst(rst), .led_in(led_in),
		.led_out(led_out), .led_oe(led_oe),
		.skip_memory_selftest(opts[6]), .mgmt_port_voltage_select(opts[5]),
		.clock_freq_select_bit1(opts[4]), .wan_port_mode(opts[3]),
		.mgmt_port_mode(opts[2]), .cpu_eeprom_select(opts[1]),
		.hw_forwarding_enable(opts[0]), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w),
		.wb_dat_o(dat_r), .wb_ack_o(ack));
	slp_board u_board (.fitted(fitted), .strap_lvl(s_lvl),
		.led_out(led_out), .led_oe(led_oe), .led_in(led_in), .lit(lit));

	task automatic chk(input string what, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// holds the request until ack is sampled high at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk("ack", {31'h0, ack}, 32'h1);
	endtask

	task automatic leds(input logic [15:0] v, input logic [15:0] exp);
		bus(1'b1, `SLP_ADR_LEDS, {16'h0, v});
		repeat (2) @(posedge clk);
		chk("led_out", {16'h0, led_out}, {16'h0, exp});
	endtask

	task automatic results();
		if (mismatches == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			results();
		end
	end

	initial begin
		int n;
		{rst, fitted, cyc, stb, we, s_lvl, adr, dat_w} = {1'b1, 22'h0, 32'h0};
		foreach (cases[i]) begin
			@(posedge clk);
			rst <= 1'b1;
			{fitted, s_lvl} <= cases[i];
			repeat (2) @(posedge clk);
			chk("oe_reset", {16'h0, led_oe}, 32'h0);
			rst <= 1'b0;
			@(posedge clk);
			chk("oe_sample", {16'h0, led_oe}, 32'h0);
			n = 0;
			while (led_oe !== 16'hFFFF && n < 40) begin
				@(posedge clk);
				n++;
			end
			cap = cases[i][10] ? cases[i][9:0] : `SLP_STRAP_DFLT;
			repeat (2) @(posedge clk);
			chk("oe_run", {16'h0, led_oe}, 32'hFFFF);
			chk("opts", {25'h0, opts}, {25'h0, cap[1], cap[2], cap[3], cap[4],
				cap[6], cap[8], cap[9]});
			bus(1'b0, `SLP_ADR_STATUS, 32'h0);
			chk("done", rd, 32'h1);
			bus(1'b0, 8'h10, 32'h0);
			chk("unmapped", rd, 32'h0);
			bus(1'b1, `SLP_ADR_STRAP, 32'h3FF);
			foreach (cases[k]) begin
				st = {cases[k][5:0], cases[k][9:0]} ^ 16'hA53C;
				leds(st, ~(st ^ {6'h00, cap}));
				chk("lit", {16'h0, lit}, {16'h0, st});
			end
			// pins have toggled as outputs; capture must not follow them
			bus(1'b0, `SLP_ADR_STRAP, 32'h0);
			chk("strap", rd, {22'h0, cap});
			bus(1'b1, `SLP_ADR_CTRL, 32'h1);
			leds(16'h5AC3, 16'hA53C);
			bus(1'b0, `SLP_ADR_CTRL, 32'h0);
			chk("ctrl", rd, 32'h1);
			bus(1'b0, `SLP_ADR_LEDS, 32'h0);
			chk("leds_rd", rd, 32'h5AC3);
			bus(1'b1, `SLP_ADR_CTRL, 32'h0);
		end
		results();
	end
endmodule
